// [include/dcbd_consts.svh]
// Offsets, field positions, reset values and sizes of the config byte decoder
`ifndef DCBD_CONSTS_SVH
`define DCBD_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DCBD_ADDR_W      24
`define DCBD_OFF_CFG3L   24'h300004
`define DCBD_OFF_CFG3H   24'h300005
`define DCBD_OFF_CFG4L   24'h300006
`define DCBD_OFF_PINCTL  24'h300010
`define DCBD_OFF_STATUS  24'h300011

// ****************************************
// Implemented bits and power-up values
// ****************************************
`define DCBD_MASK_3H     8'h87
`define DCBD_MASK_3H_SM  8'h85
`define DCBD_MASK_4L     8'hf5
`define DCBD_RST_3H      8'h83
`define DCBD_RST_4L      8'h85
`define DCBD_RST_PINCTL  8'h00
`define DCBD_PINCTL_MASK 8'h0f

// ****************************************
// Field positions
// ****************************************
`define DCBD_B_RSTPIN    7
`define DCBD_B_LPOSC     2
`define DCBD_B_PWMRT     1
`define DCBD_B_CC2RT     0
`define DCBD_B_DEBUG     7
`define DCBD_B_EXTENDED_INSTR_ENABLE     6
`define DCBD_B_BBSZ_HI   5
`define DCBD_B_BBSZ_LO   4
`define DCBD_B_LVP       2
`define DCBD_B_STACK_FAULT_RESET_ENABLE    0

// ****************************************
// Boot block sizes in words, mode codes
// ****************************************
`define DCBD_WADDR_W     17
`define DCBD_BB_4K       17'h01000
`define DCBD_BB_2K       17'h00800
`define DCBD_BB_1K       17'h00400
`define DCBD_PM_MCU      2'h3

`endif

// [include/dcbd_pkg.sv]
// Types shared by the config byte decoder modules
`default_nettype none
package dcbd_pkg;

   typedef struct packed {
      logic [7:0] opt_hi;
      logic [7:0] dbg_lo;
   } dcbd_cfg_s;

   typedef struct packed {
      logic [3:0] dat;
      logic [3:0] oe;
   } dcbd_pin_s;

endpackage

`default_nettype wire

// [verilog/dcbd_cfg_latch.sv]
// Captures the nonvolatile config bytes once after reset and holds them
`timescale 1ns/1ps
`default_nettype none
`include "dcbd_consts.svh"

module dcbd_cfg_latch
   import dcbd_pkg::*;
#(
   parameter logic [7:0] MASK_HI = `DCBD_MASK_3H
) (
   input  wire logic      sys_clk_in,
   input  wire logic      rst_b_in,
   input  wire dcbd_cfg_s cfg_image_in,
   output dcbd_cfg_s      cfg_out,
   output logic           ready_out
);

   wire dcbd_cfg_s masked_image;

   assign masked_image.opt_hi = cfg_image_in.opt_hi & MASK_HI;
   assign masked_image.dbg_lo = cfg_image_in.dbg_lo & `DCBD_MASK_4L;

   // Load once; later image changes wait for the next reset
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         // Masked so the small package never shows the routing bit
         cfg_out   <= {`DCBD_RST_3H & MASK_HI, `DCBD_RST_4L};
         ready_out <= 1'b0;
      end else if (!ready_out) begin
         cfg_out   <= masked_image;
         ready_out <= 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_cfg_load_value: assert property (
      !ready_out |=> ready_out && cfg_out == $past(masked_image))
      else $error("config bytes not captured after reset");

   a_cfg_held_still: assert property (
      ready_out |=> $stable(cfg_out) && ready_out)
      else $error("latched config changed while running");

endmodule // dcbd_cfg_latch

`default_nettype wire

// [verilog/dcbd_boot_guard.sv]
// Boot block extent from the size field and the guarded fetch region
`timescale 1ns/1ps
`default_nettype none
`include "dcbd_consts.svh"

module dcbd_boot_guard (
   input  wire logic                     sys_clk_in,
   input  wire logic                     rst_b_in,
   input  wire logic [1:0]               size_code_in,
   input  wire logic [`DCBD_WADDR_W-1:0] fetch_addr_in,
   input  wire logic                     protect_en_in,
   output logic [`DCBD_WADDR_W-1:0]      block_words_out,
   output logic                          in_block_out,
   output logic                          guard_hit_out
);

   wire [`DCBD_WADDR_W-1:0] next_words;
   wire                     next_in_block;

   assign next_words = size_code_in[1] ? `DCBD_BB_4K :
                       (size_code_in[0] ? `DCBD_BB_2K : `DCBD_BB_1K);
   assign next_in_block = fetch_addr_in < next_words;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         block_words_out <= `DCBD_BB_1K;
         in_block_out    <= 1'b0;
         guard_hit_out   <= 1'b0;
      end else begin
         block_words_out <= next_words;
         in_block_out    <= next_in_block;
         guard_hit_out   <= next_in_block & protect_en_in;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_boot_size_map: assert property (
      size_code_in == 2'h1 |=> block_words_out == 17'h00800)
      else $error("size code 01 did not give 2K words");

   a_boot_size_big: assert property (
      size_code_in[1] |=> block_words_out == 17'h01000)
      else $error("size codes 1x did not give 4K words");

   a_boot_guard_hit: assert property (
      protect_en_in && size_code_in[1] && fetch_addr_in == 17'h00fff |=> guard_hit_out)
      else $error("last boot word not guarded");

endmodule // dcbd_boot_guard

`default_nettype wire

// [verilog/dcbd_config_decode.sv]
// Config byte decoder: option latch, pin routing and register port
//
// What this block does
// - Reset pin enable: reset input, else general input
// - Timer1 oscillator low power when bit set
// - Route set: PWM aux to port E 6..3
// - Route clear: PWM aux to port H 7..4
// - PWM routing only on large package
// - Unit2 route set: uses port C bit 1
// - Route clear: port B3, or E7 microcontroller
// - Unimplemented config bits read as zero
// - Boot size codes: 11,10 4K; 01 2K
// - Third config low byte absent, reads zero on both packages
// - Boot size sets guarded boot region extent
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dcbd_consts.svh"

module dcbd_config_decode
   import dcbd_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1
) (
   input  wire logic                     sys_clk_in,
   input  wire logic                     rst_b_in,
   input  wire dcbd_cfg_s                cfg_image_in,
   input  wire logic [`DCBD_ADDR_W-1:0]  reg_addr_in,
   input  wire logic [7:0]               reg_wdata_in,
   input  wire logic                     reg_wr_in,
   input  wire logic                     reg_rd_in,
   output logic [7:0]                    reg_rdata_out,
   input  wire logic [1:0]               proc_mode_in,
   input  wire logic                     external_reset_pin_in,
   output logic                          ext_reset_req_out,
   output logic                          port_g_bit5_input_out,
   output logic                          low_power_timer1_osc_sel_out,
   input  wire logic [3:0]               pwm_aux_in,
   output dcbd_pin_s                     port_e_pwm_out,
   output dcbd_pin_s                     port_h_pwm_out,
   input  wire logic                     capcmp2_out_in,
   input  wire logic                     capcmp2_oe_in,
   output logic                          capcmp2_in_out,
   input  wire logic                     port_c_bit1_in,
   output logic                          port_c_bit1_out,
   output logic                          port_c_bit1_oe_out,
   input  wire logic                     port_b_bit3_in,
   output logic                          port_b_bit3_out,
   output logic                          port_b_bit3_oe_out,
   input  wire logic                     port_e_bit7_in,
   output logic                          port_e_bit7_out,
   output logic                          port_e_bit7_oe_out,
   input  wire logic [`DCBD_WADDR_W-1:0] fetch_addr_in,
   input  wire logic                     boot_protect_in,
   output logic [`DCBD_WADDR_W-1:0]      boot_block_words_out,
   output logic                          boot_region_out,
   output logic                          boot_guard_hit_out,
   output logic                          debug_enable_out,
   output logic                          extended_instr_enable_out,
   output logic                          single_supply_prog_enable_out,
   output logic                          stack_fault_reset_enable_out,
   output logic                          cfg_ready_out
);

   // ****************************************
   // Option latch
   // ****************************************
   localparam logic [7:0] MASK_HI = LARGE_PKG ? `DCBD_MASK_3H : `DCBD_MASK_3H_SM;

   dcbd_cfg_s cfg_q;
   logic      cfg_ready;

   dcbd_cfg_latch #(
      .MASK_HI      (MASK_HI)
   ) u_latch (
      .sys_clk_in   (sys_clk_in),
      .rst_b_in     (rst_b_in),
      .cfg_image_in (cfg_image_in),
      .cfg_out      (cfg_q),
      .ready_out    (cfg_ready)
   );

   // ****************************************
   // Decoded option fields
   // ****************************************
   wire       opt_rst_pin  = cfg_q.opt_hi[`DCBD_B_RSTPIN];
   wire       opt_lp_osc   = cfg_q.opt_hi[`DCBD_B_LPOSC];
   wire       opt_pwm_rt   = cfg_q.opt_hi[`DCBD_B_PWMRT];
   wire       opt_cc2_rt   = cfg_q.opt_hi[`DCBD_B_CC2RT];
   wire [1:0] opt_bb_size  = cfg_q.dbg_lo[`DCBD_B_BBSZ_HI:`DCBD_B_BBSZ_LO];
   wire       mode_mcu     = proc_mode_in == `DCBD_PM_MCU;

   // Small package has no port H, so its route is fixed on port E
   wire       route_to_e   = LARGE_PKG ? opt_pwm_rt : 1'b1;
   wire       cc2_on_c     = opt_cc2_rt;
   wire       cc2_on_b     = !opt_cc2_rt && !mode_mcu;
   wire       cc2_on_e7    = !opt_cc2_rt && mode_mcu;

   assign low_power_timer1_osc_sel_out  = opt_lp_osc;
   assign debug_enable_out              = cfg_q.dbg_lo[`DCBD_B_DEBUG];
   assign extended_instr_enable_out     = cfg_q.dbg_lo[`DCBD_B_EXTENDED_INSTR_ENABLE];
   assign single_supply_prog_enable_out = cfg_q.dbg_lo[`DCBD_B_LVP];
   assign stack_fault_reset_enable_out  = cfg_q.dbg_lo[`DCBD_B_STACK_FAULT_RESET_ENABLE];
   assign cfg_ready_out                 = cfg_ready;

   // ****************************************
   // Boot block extent
   // ****************************************
   dcbd_boot_guard u_boot (
      .sys_clk_in      (sys_clk_in),
      .rst_b_in        (rst_b_in),
      .size_code_in    (opt_bb_size),
      .fetch_addr_in   (fetch_addr_in),
      .protect_en_in   (boot_protect_in),
      .block_words_out (boot_block_words_out),
      .in_block_out    (boot_region_out),
      .guard_hit_out   (boot_guard_hit_out)
   );

   // ****************************************
   // Register port decode
   // ****************************************
   logic [7:0] pin_ctl;

   wire hit_3l     = reg_addr_in == `DCBD_OFF_CFG3L;
   wire hit_3h     = reg_addr_in == `DCBD_OFF_CFG3H;
   wire hit_4l     = reg_addr_in == `DCBD_OFF_CFG4L;
   wire hit_pinctl = reg_addr_in == `DCBD_OFF_PINCTL;
   wire hit_status = reg_addr_in == `DCBD_OFF_STATUS;

   // Config bytes are read only here; only the programmer alters them
   wire pinctl_wr = reg_wr_in && hit_pinctl;

   wire [7:0] status_word = {5'h00, proc_mode_in, cfg_ready};

   // Low config byte of bank three is not modelled and always reads zero
   wire [7:0] next_rdata =
      hit_3l     ? 8'h00 :
      hit_3h     ? cfg_q.opt_hi & MASK_HI :
      hit_4l     ? cfg_q.dbg_lo & `DCBD_MASK_4L :
      hit_pinctl ? pin_ctl :
      hit_status ? status_word :
      8'h00;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pin_ctl <= `DCBD_RST_PINCTL;
      end else if (pinctl_wr) begin
         pin_ctl <= reg_wdata_in & `DCBD_PINCTL_MASK;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= reg_rd_in ? next_rdata : 8'h00;
      end
   end

   // ****************************************
   // Shared reset pin
   // ****************************************
   // Pin is active low; when enabled the general input reads zero
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_reset_req_out     <= 1'b0;
         port_g_bit5_input_out <= 1'b0;
      end else begin
         ext_reset_req_out     <= opt_rst_pin && !external_reset_pin_in;
         port_g_bit5_input_out <= !opt_rst_pin && external_reset_pin_in;
      end
   end

   // ****************************************
   // PWM auxiliary routing, one slice per output
   // ****************************************
   // Drive waits for software enable so a pin is never claimed by surprise
   genvar gi;
   wire dcbd_pin_s next_e_pwm;
   wire dcbd_pin_s next_h_pwm;

   generate
      for (gi = 0; gi < 4; gi++) begin : g_aux
         wire drive_en = pin_ctl[gi];
         assign next_e_pwm.dat[gi] = route_to_e && pwm_aux_in[gi];
         assign next_e_pwm.oe[gi]  = route_to_e && drive_en;
         assign next_h_pwm.dat[gi] = !route_to_e && pwm_aux_in[gi];
         assign next_h_pwm.oe[gi]  = !route_to_e && drive_en;
      end
   endgenerate

   // One register stage, so routed pins settle a cycle after inputs
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         port_e_pwm_out <= '0;
         port_h_pwm_out <= '0;
      end else begin
         port_e_pwm_out <= next_e_pwm;
         port_h_pwm_out <= next_h_pwm;
      end
   end

   // ****************************************
   // Capture/compare unit 2 routing
   // ****************************************
   wire next_cc2_in = (cc2_on_c  && port_c_bit1_in) ||
                      (cc2_on_b  && port_b_bit3_in) ||
                      (cc2_on_e7 && port_e_bit7_in);

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         port_c_bit1_out    <= 1'b0;
         port_c_bit1_oe_out <= 1'b0;
         port_b_bit3_out    <= 1'b0;
         port_b_bit3_oe_out <= 1'b0;
         port_e_bit7_out    <= 1'b0;
         port_e_bit7_oe_out <= 1'b0;
         capcmp2_in_out     <= 1'b0;
      end else begin
         port_c_bit1_out    <= cc2_on_c && capcmp2_out_in;
         port_c_bit1_oe_out <= cc2_on_c && capcmp2_oe_in;
         port_b_bit3_out    <= cc2_on_b && capcmp2_out_in;
         port_b_bit3_oe_out <= cc2_on_b && capcmp2_oe_in;
         port_e_bit7_out    <= cc2_on_e7 && capcmp2_out_in;
         port_e_bit7_oe_out <= cc2_on_e7 && capcmp2_oe_in;
         capcmp2_in_out     <= next_cc2_in;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_reset_pin_req: assert property (
      cfg_ready && opt_rst_pin && !external_reset_pin_in
      |=> ext_reset_req_out && !port_g_bit5_input_out)
      else $error("enabled reset pin did not raise reset");

   a_gpio_pin_use: assert property (
      cfg_ready && !opt_rst_pin
      |=> !ext_reset_req_out && port_g_bit5_input_out == $past(external_reset_pin_in))
      else $error("general input path wrong with reset pin off");

   a_timer_osc_mode: assert property (
      $rose(cfg_ready) |-> low_power_timer1_osc_sel_out == $past(cfg_image_in.opt_hi[2]))
      else $error("timer oscillator select does not follow option");

   a_route_port_e: assert property (
      cfg_ready && opt_pwm_rt
      |=> port_e_pwm_out.oe == $past(pin_ctl[3:0]) && port_e_pwm_out.dat == $past(pwm_aux_in)
          && port_h_pwm_out.oe == 4'h0)
      else $error("aux outputs not on port E");

   a_route_port_h: assert property (
      cfg_ready && !opt_pwm_rt && LARGE_PKG
      |=> port_h_pwm_out.oe == $past(pin_ctl[3:0]) && port_h_pwm_out.dat == $past(pwm_aux_in)
          && port_e_pwm_out.oe == 4'h0)
      else $error("aux outputs not on port H");

   a_small_no_route: assert property (
      !LARGE_PKG |-> port_h_pwm_out.oe == 4'h0 && cfg_q.opt_hi[1] == 1'b0)
      else $error("routing option active on small package");

   a_cc2_on_c1: assert property (
      cfg_ready && opt_cc2_rt
      |=> port_c_bit1_oe_out == $past(capcmp2_oe_in) && !port_b_bit3_oe_out
          && !port_e_bit7_oe_out)
      else $error("unit 2 not on port C bit 1");

   a_cc2_alt_pin: assert property (
      cfg_ready && !opt_cc2_rt && capcmp2_oe_in
      |=> (port_e_bit7_oe_out == $past(mode_mcu)) && (port_b_bit3_oe_out != $past(mode_mcu))
          && !port_c_bit1_oe_out)
      else $error("unit 2 alternate pin wrong for mode");

   a_unimpl_zero: assert property (
      reg_rd_in && (hit_3h || hit_4l)
      |=> (reg_rdata_out & ~($past(hit_3h) ? MASK_HI : 8'hf5)) == 8'h00)
      else $error("unimplemented config bit read as one");

   a_cfg3l_absent: assert property (
      reg_rd_in && hit_3l |=> reg_rdata_out == 8'h00)
      else $error("absent config byte read nonzero");

   a_read_one_cycle: assert property (
      cfg_ready && reg_rd_in && hit_3h ##1 !reg_rd_in
      |-> reg_rdata_out == (cfg_q.opt_hi & MASK_HI) ##1 reg_rdata_out == 8'h00)
      else $error("config readback wrong or held too long");

   a_gpio_off_zero: assert property (
      cfg_ready && opt_rst_pin |=> !port_g_bit5_input_out)
      else $error("general input not blocked with reset pin on");

   a_aux_one_port: assert property (
      (port_e_pwm_out.oe & port_h_pwm_out.oe) == 4'h0)
      else $error("aux output driven on both ports");

   a_cc2_one_pin: assert property (
      $onehot0({port_c_bit1_oe_out, port_b_bit3_oe_out, port_e_bit7_oe_out})
      && $onehot0({port_c_bit1_out, port_b_bit3_out, port_e_bit7_out}))
      else $error("unit 2 claims more than one pin");

   a_cc2_input_sel: assert property (
      cfg_ready |=> capcmp2_in_out == $past(opt_cc2_rt ? port_c_bit1_in :
                                            (mode_mcu ? port_e_bit7_in : port_b_bit3_in)))
      else $error("unit 2 input taken from wrong pin");

   a_debug_opts_load: assert property (
      $rose(cfg_ready) |-> debug_enable_out == $past(cfg_image_in.dbg_lo[7])
          && extended_instr_enable_out == $past(cfg_image_in.dbg_lo[6])
          && single_supply_prog_enable_out == $past(cfg_image_in.dbg_lo[2])
          && stack_fault_reset_enable_out == $past(cfg_image_in.dbg_lo[0]))
      else $error("debug and boot option bits not loaded");

   a_opts_held_run: assert property (
      cfg_ready |=> $stable({low_power_timer1_osc_sel_out, debug_enable_out,
                            extended_instr_enable_out, single_supply_prog_enable_out,
                            stack_fault_reset_enable_out}))
      else $error("option outputs changed while running");

   a_pinctl_write: assert property (
      reg_wr_in && hit_pinctl |=> pin_ctl == ($past(reg_wdata_in) & 8'h0f))
      else $error("pin control write not taken");

   a_cfg_write_ign: assert property (
      reg_wr_in && !hit_pinctl |=> $stable(pin_ctl))
      else $error("write to read-only offset changed state");

   a_status_read: assert property (
      reg_rd_in && hit_status
      |=> reg_rdata_out == {5'h00, $past(proc_mode_in), $past(cfg_ready)})
      else $error("status byte read wrong");

   a_rdata_idle_zero: assert property (
      !reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data stood past its cycle");

   a_boot_hit_region: assert property (
      boot_guard_hit_out |-> boot_region_out && $past(boot_protect_in))
      else $error("boot guard hit outside protected region");

endmodule // dcbd_config_decode

`default_nettype wire

// [bench/tb_dcbd_config_decode.sv]
// Self-checking bench of the config byte decoder, both package sizes
`timescale 1ns/1ps
`default_nettype none
`include "dcbd_consts.svh"

module tb_dcbd_config_decode
   import dcbd_pkg::*;
;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   dcbd_cfg_s   img;
   logic [23:0] addr;
   logic [7:0]  wd, rd_l, rd_s, oc, dc, a, b;
   logic        wr, rd, xrst, c2o, c2oe, pc1, pb3, pe7, prot;
   logic [1:0]  pm;
   logic [3:0]  aux;
   logic [16:0] fa, bw, bwexp;
   logic        xreq, pg5, lpt, c2i, pc1o, pc1e, pb3o, pb3e, pe7o, pe7e;
   logic        breg, bhit, dbg, xin, ssp, stv, rdy;
   dcbd_pin_s   pe_l, ph_l, pe_s, ph_s;
   int          n_fail = 0;
   int          compares = 0;
   int          cyc = 0;
   logic [15:0] corner [5] = '{16'h8385, 16'h0000, 16'hffff, 16'h0295, 16'h01a4};

   dcbd_config_decode #(.LARGE_PKG(1'b1)) uut (
      .sys_clk_in(clk), .rst_b_in(rst_b), .cfg_image_in(img), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rd_l),
      .proc_mode_in(pm), .external_reset_pin_in(xrst), .ext_reset_req_out(xreq),
      .port_g_bit5_input_out(pg5), .low_power_timer1_osc_sel_out(lpt),
      .pwm_aux_in(aux), .port_e_pwm_out(pe_l), .port_h_pwm_out(ph_l),
      .capcmp2_out_in(c2o), .capcmp2_oe_in(c2oe), .capcmp2_in_out(c2i),
      .port_c_bit1_in(pc1), .port_c_bit1_out(pc1o), .port_c_bit1_oe_out(pc1e),
      .port_b_bit3_in(pb3), .port_b_bit3_out(pb3o), .port_b_bit3_oe_out(pb3e),
      .port_e_bit7_in(pe7), .port_e_bit7_out(pe7o), .port_e_bit7_oe_out(pe7e),
      .fetch_addr_in(fa), .boot_protect_in(prot), .boot_block_words_out(bw),
      .boot_region_out(breg), .boot_guard_hit_out(bhit), .debug_enable_out(dbg),
      .extended_instr_enable_out(xin), .single_supply_prog_enable_out(ssp),
      .stack_fault_reset_enable_out(stv), .cfg_ready_out(rdy));

   // Small package copy shares every input; only its routing and config readback are judged
   dcbd_config_decode #(.LARGE_PKG(1'b0)) uut_small (
      .sys_clk_in(clk), .rst_b_in(rst_b), .cfg_image_in(img), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rd_s),
      .proc_mode_in(pm), .external_reset_pin_in(xrst), .ext_reset_req_out(),
      .port_g_bit5_input_out(), .low_power_timer1_osc_sel_out(),
      .pwm_aux_in(aux), .port_e_pwm_out(pe_s), .port_h_pwm_out(ph_s),
      .capcmp2_out_in(c2o), .capcmp2_oe_in(c2oe), .capcmp2_in_out(),
      .port_c_bit1_in(pc1), .port_c_bit1_out(), .port_c_bit1_oe_out(),
      .port_b_bit3_in(pb3), .port_b_bit3_out(), .port_b_bit3_oe_out(),
      .port_e_bit7_in(pe7), .port_e_bit7_out(), .port_e_bit7_oe_out(),
      .fetch_addr_in(fa), .boot_protect_in(prot), .boot_block_words_out(),
      .boot_region_out(), .boot_guard_hit_out(), .debug_enable_out(),
      .extended_instr_enable_out(), .single_supply_prog_enable_out(),
      .stack_fault_reset_enable_out(), .cfg_ready_out());

   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   always #20 clk = ~clk;

   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         wrap_up();
      end
   end

   function automatic logic [16:0] exp_words(input logic [1:0] code);
      case (code)
         2'b11, 2'b10: return `DCBD_BB_4K;
         2'b01: return `DCBD_BB_2K;
         default: return `DCBD_BB_1K;
      endcase
   endfunction

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected read at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected output at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic reg_rd(input logic [23:0] ad, output logic [7:0] dl, output logic [7:0] ds);
      @(posedge clk);
      rd <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      dl = rd_l;
      ds = rd_s;
   endtask

   task automatic reg_wr(input logic [23:0] ad, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= ad;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic wrap_up();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {addr, wd, wr, rd, xrst, c2o, c2oe, pc1, pb3, pe7, prot, aux, fa, pm} = '0;
      img = 16'h8385;
      void'($urandom(3));
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         img <= (i < 5) ? corner[i] : 16'($urandom);
         pm <= 2'($urandom);
         rst_b <= 1'b0;
         repeat (3) @(posedge clk);
         rst_b <= 1'b1;
         repeat (3) @(posedge clk);
         #1;
         oc = img.opt_hi;
         dc = img.dbg_lo;
         bwexp = exp_words(dc[5:4]);
         chk_sig(rdy, 1);
         reg_wr(`DCBD_OFF_PINCTL, 8'hff);
         reg_wr(`DCBD_OFF_CFG3H, ~oc);
         reg_rd(`DCBD_OFF_CFG3H, a, b);
         chk_reg(a, oc & `DCBD_MASK_3H);
         chk_reg(b, oc & `DCBD_MASK_3H_SM);
         reg_rd(`DCBD_OFF_CFG4L, a, b);
         chk_reg(a, dc & `DCBD_MASK_4L);
         reg_rd(`DCBD_OFF_CFG3L, a, b);
         chk_reg(a | b, 8'h00);
         reg_rd(`DCBD_OFF_PINCTL, a, b);
         chk_reg(a, 8'h0f);
         reg_rd(`DCBD_OFF_STATUS, a, b);
         chk_reg(a, {5'h00, pm, 1'b1});
         reg_rd(24'h300007, a, b);
         chk_reg(a, 8'h00);
         // Image flips while running; decoded options must not follow
         for (int j = 0; j < 6; j++) begin
            @(posedge clk);
            if (j == 0) begin
               img <= ~img;
            end
            {aux, c2o, c2oe, pc1, pb3, pe7, xrst, prot} <= 11'($urandom);
            fa <= (j < 2) ? bwexp - 17'(1 - j) : 17'($urandom % 'h1400);
            @(posedge clk);
            #1;
            chk_sig(xreq, oc[7] & ~xrst);
            chk_sig(pg5, ~oc[7] & xrst);
            chk_sig(lpt, oc[2]);
            chk_sig(pe_l, oc[1] ? {aux, 4'hf} : 8'h00);
            chk_sig(ph_l, oc[1] ? 8'h00 : {aux, 4'hf});
            chk_sig({pe_s, ph_s}, {aux, 4'hf, 8'h00});
            chk_sig({pc1o, pc1e}, oc[0] ? {c2o, c2oe} : 2'b00);
            chk_sig({pb3o, pb3e, pe7o, pe7e}, oc[0] ? 4'h0 :
                    (pm == `DCBD_PM_MCU) ? {2'b00, c2o, c2oe} : {c2o, c2oe, 2'b00});
            chk_sig(c2i, oc[0] ? pc1 : (pm == `DCBD_PM_MCU) ? pe7 : pb3);
            chk_sig(bw, bwexp);
            chk_sig({breg, bhit}, {fa < bwexp, (fa < bwexp) & prot});
            chk_sig({dbg, xin, ssp, stv}, {dc[7], dc[6], dc[2], dc[0]});
         end
         reg_rd(`DCBD_OFF_CFG3H, a, b);
         chk_reg(a, oc & `DCBD_MASK_3H);
      end
      wrap_up();
   end

endmodule // tb_dcbd_config_decode
`default_nettype wire
